// *** rtl/ccp_capture_compare_channel.v ***
`include "ccp_defs.vh"

module ccp_capture_compare_channel (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    output wire        irq_o,
    input  wire [15:0] timer_a_count_i,
    input  wire [15:0] timer_b_count_i,
    output wire        timer_a_reset_o,
    output wire        timer_b_reset_o,
    input  wire        channel_pin_i,
    output wire        channel_pin_o,
    output wire        channel_pin_oe_o
);

    reg  [3:0]  mode_ff;
    reg         timer_sel_ff;
    reg  [15:0] value_ff;
    reg         flag_ff;
    reg         irq_en_ff;
    reg         port_latch_ff;
    reg         pin_dir_ff;
    reg         cmp_latch_ff;
    reg  [3:0]  pre_cnt_ff;
    reg         pin_meta_ff;
    reg         pin_sync_ff;
    reg         edge_src_ff;
    reg         match_prev_ff;
    reg         ack_ff;
    reg  [31:0] dat_ff;
    reg         irq_ff;
    reg         timer_a_reset_ff;
    reg         timer_b_reset_ff;
    reg         pin_out_ff;
    reg         pin_oe_ff;

    reg  [3:0]  nxt_mode;
    reg  [15:0] nxt_value;
    reg         nxt_flag;
    reg         nxt_cmp_latch;
    reg  [3:0]  nxt_pre_cnt;
    reg  [31:0] nxt_dat;
    reg         nxt_timer_sel;
    reg         nxt_irq_en;
    reg         nxt_port_latch;
    reg         nxt_pin_dir;
    reg         nxt_irq;
    reg         nxt_ta_rst;
    reg         nxt_tb_rst;
    reg         nxt_pin_out;
    reg         nxt_pin_oe;

    wire        bus_req;
    wire        wr_en;
    wire        wr_lane0;
    wire        is_capture;
    wire        is_compare;
    wire        edge_src;
    wire        rise;
    wire        fall;
    wire [15:0] timer_count;
    wire        match_now;
    wire        match_hit;
    wire        capture_hit;
    wire        flag_clear;

    // true for the four capture encodings
    function cap_mode;
        input [3:0] m;
        begin
            cap_mode = (m == `CCP_MODE_CAP_FALL) ||
                       (m == `CCP_MODE_CAP_RISE) ||
                       (m == `CCP_MODE_CAP_RISE4) ||
                       (m == `CCP_MODE_CAP_RISE16);
        end
    endfunction

    // true for the five compare encodings
    function cmp_mode;
        input [3:0] m;
        begin
            cmp_mode = (m == `CCP_MODE_CMP_TOGGLE) ||
                       (m == `CCP_MODE_CMP_SET) ||
                       (m == `CCP_MODE_CMP_CLEAR) ||
                       (m == `CCP_MODE_CMP_SWIRQ) ||
                       (m == `CCP_MODE_CMP_SPECIAL);
        end
    endfunction

    // write strobe for one register offset
    function wr_hit;
        input       lane0;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            wr_hit = lane0 && (adr == ofs);
        end
    endfunction

    // wishbone slave: one wait state, ack for one cycle
    assign bus_req  = cyc_i & stb_i & ~ack_ff;
    assign wr_en    = bus_req & we_i;
    assign wr_lane0 = wr_en & sel_i[0];

    assign is_capture = cap_mode(mode_ff);
    assign is_compare = cmp_mode(mode_ff);

    // pin sync, first stage read only by the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= channel_pin_i;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // output pin follows port latch internally, so port writes cause events
    assign edge_src = pin_dir_ff ? pin_sync_ff : port_latch_ff;
    assign rise     = edge_src & ~edge_src_ff;
    assign fall     = ~edge_src & edge_src_ff;

    assign timer_count = timer_sel_ff ? timer_b_count_i
                                      : timer_a_count_i;
    assign match_now = (timer_count == value_ff);
    assign match_hit = is_compare & match_now & ~match_prev_ff;

    assign flag_clear = wr_hit(wr_lane0, adr_i, `CCP_OFS_IRQ_CLEAR) &
                        dat_i[`CCP_EVENT_BIT];

    // capture event and prescaler
    reg cap_hit_r;
    assign capture_hit = cap_hit_r;
    always @* begin
        cap_hit_r   = 1'b0;
        nxt_pre_cnt = pre_cnt_ff;
        case (mode_ff)
            `CCP_MODE_CAP_FALL: begin
                cap_hit_r = fall;
            end
            `CCP_MODE_CAP_RISE: begin
                cap_hit_r = rise;
            end
            `CCP_MODE_CAP_RISE4: begin
                if (rise) begin
                    if (pre_cnt_ff >= `CCP_PRE_LAST4) begin
                        cap_hit_r   = 1'b1;
                        nxt_pre_cnt = 4'h0;
                    end else begin
                        nxt_pre_cnt = pre_cnt_ff + 4'h1;
                    end
                end
            end
            `CCP_MODE_CAP_RISE16: begin
                if (rise) begin
                    if (pre_cnt_ff == `CCP_PRE_LAST16) begin
                        cap_hit_r   = 1'b1;
                        nxt_pre_cnt = 4'h0;
                    end else begin
                        nxt_pre_cnt = pre_cnt_ff + 4'h1;
                    end
                end
            end
            default: begin
                nxt_pre_cnt = 4'h0;
            end
        endcase
    end

    // control, value, flag and compare latch
    always @* begin
        nxt_mode      = mode_ff;
        nxt_value     = value_ff;
        nxt_cmp_latch = cmp_latch_ff;
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_CONTROL)) begin
            nxt_mode = dat_i[3:0];
            if (dat_i[3:0] == `CCP_MODE_OFF) begin
                nxt_cmp_latch = 1'b0;
            end
        end
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_VALUE_LOW)) begin
            nxt_value[7:0] = dat_i[7:0];
        end
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_VALUE_HIGH)) begin
            nxt_value[15:8] = dat_i[7:0];
        end
        if (capture_hit) begin
            nxt_value = timer_count;
        end
        if (match_hit) begin
            case (mode_ff)
                `CCP_MODE_CMP_SET:    nxt_cmp_latch = 1'b1;
                `CCP_MODE_CMP_CLEAR:  nxt_cmp_latch = 1'b0;
                `CCP_MODE_CMP_TOGGLE: nxt_cmp_latch = ~cmp_latch_ff;
                default:              nxt_cmp_latch = cmp_latch_ff;
            endcase
        end
        // set wins over a simultaneous clear
        nxt_flag = (flag_ff & ~flag_clear) |
                   capture_hit | match_hit;
    end

    // loose control bits
    always @* begin
        nxt_timer_sel  = timer_sel_ff;
        nxt_irq_en     = irq_en_ff;
        nxt_port_latch = port_latch_ff;
        nxt_pin_dir    = pin_dir_ff;
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_TIMER_SEL)) begin
            nxt_timer_sel = dat_i[0];
        end
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_IRQ_ENABLE)) begin
            nxt_irq_en = dat_i[`CCP_EVENT_BIT];
        end
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_PORT_LATCH)) begin
            nxt_port_latch = dat_i[0];
        end
        if (wr_hit(wr_lane0, adr_i, `CCP_OFS_PIN_DIR)) begin
            nxt_pin_dir = dat_i[0];
        end
    end

    // interrupt level, special event trigger and pin drive
    always @* begin
        nxt_irq    = nxt_flag & nxt_irq_en;
        // trigger resets the selected timer only; no converter output
        nxt_ta_rst = match_hit & ~timer_sel_ff &
                     (mode_ff == `CCP_MODE_CMP_SPECIAL);
        nxt_tb_rst = match_hit & timer_sel_ff &
                     (mode_ff == `CCP_MODE_CMP_SPECIAL);
        nxt_pin_oe = ~nxt_pin_dir;
        // latch-driving compare modes drive from the compare latch
        if (nxt_mode == `CCP_MODE_CMP_SET ||
            nxt_mode == `CCP_MODE_CMP_CLEAR ||
            nxt_mode == `CCP_MODE_CMP_TOGGLE) begin
            nxt_pin_out = nxt_cmp_latch;
        end else begin
            nxt_pin_out = nxt_port_latch;
        end
    end

    // register read mux
    always @* begin
        nxt_dat = 32'h0000_0000;
        case (adr_i)
            `CCP_OFS_CONTROL:    nxt_dat[3:0] = mode_ff;
            `CCP_OFS_TIMER_SEL:  nxt_dat[0] = timer_sel_ff;
            `CCP_OFS_VALUE_LOW:  nxt_dat[7:0] = value_ff[7:0];
            `CCP_OFS_VALUE_HIGH: nxt_dat[7:0] = value_ff[15:8];
            `CCP_OFS_IRQ_STATUS: nxt_dat[`CCP_EVENT_BIT] = flag_ff;
            `CCP_OFS_IRQ_ENABLE: nxt_dat[`CCP_EVENT_BIT] = irq_en_ff;
            `CCP_OFS_PORT_LATCH: nxt_dat[0] = port_latch_ff;
            `CCP_OFS_PIN_DIR:    nxt_dat[0] = pin_dir_ff;
            `CCP_OFS_STATUS: begin
                nxt_dat[`CCP_STAT_CMP_BIT] = cmp_latch_ff;
                nxt_dat[`CCP_STAT_PIN_BIT] = pin_sync_ff;
                nxt_dat[`CCP_STAT_PRE_LSB+3:`CCP_STAT_PRE_LSB] = pre_cnt_ff;
            end
            default:             nxt_dat = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff          <= `CCP_RST_MODE;
            timer_sel_ff     <= `CCP_RST_TIMER_SEL;
            value_ff         <= `CCP_RST_VALUE;
            flag_ff          <= 1'b0;
            irq_en_ff        <= 1'b0;
            port_latch_ff    <= `CCP_RST_PORT_LATCH;
            pin_dir_ff       <= `CCP_RST_PIN_DIR;
            cmp_latch_ff     <= 1'b0;
            pre_cnt_ff       <= 4'h0;
            edge_src_ff      <= 1'b0;
            match_prev_ff    <= 1'b0;
            ack_ff           <= 1'b0;
            dat_ff           <= 32'h0000_0000;
            irq_ff           <= 1'b0;
            timer_a_reset_ff <= 1'b0;
            timer_b_reset_ff <= 1'b0;
            pin_out_ff       <= 1'b0;
            pin_oe_ff        <= 1'b0;
        end else begin
            mode_ff       <= nxt_mode;
            value_ff      <= nxt_value;
            flag_ff       <= nxt_flag;
            cmp_latch_ff  <= nxt_cmp_latch;
            pre_cnt_ff    <= nxt_pre_cnt;
            edge_src_ff   <= edge_src;
            match_prev_ff <= is_compare & match_now;
            ack_ff        <= bus_req;
            if (bus_req) begin
                dat_ff <= we_i ? 32'h0000_0000 : nxt_dat;
            end
            timer_sel_ff     <= nxt_timer_sel;
            irq_en_ff        <= nxt_irq_en;
            port_latch_ff    <= nxt_port_latch;
            pin_dir_ff       <= nxt_pin_dir;
            irq_ff           <= nxt_irq;
            timer_a_reset_ff <= nxt_ta_rst;
            timer_b_reset_ff <= nxt_tb_rst;
            pin_out_ff       <= nxt_pin_out;
            pin_oe_ff        <= nxt_pin_oe;
        end
    end

    assign dat_o            = dat_ff;
    assign ack_o            = ack_ff;
    assign irq_o            = irq_ff;
    assign timer_a_reset_o  = timer_a_reset_ff;
    assign timer_b_reset_o  = timer_b_reset_ff;
    assign channel_pin_o    = pin_out_ff;
    assign channel_pin_oe_o = pin_oe_ff;

endmodule // ccp_capture_compare_channel

// *** rtl/ccp_defs.vh ***
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH

// register byte offsets
`define CCP_ADDR_W          8
`define CCP_OFS_CONTROL     8'h00
`define CCP_OFS_TIMER_SEL   8'h04
`define CCP_OFS_VALUE_LOW   8'h08
`define CCP_OFS_VALUE_HIGH  8'h0C
`define CCP_OFS_IRQ_STATUS  8'h10
`define CCP_OFS_IRQ_CLEAR   8'h14
`define CCP_OFS_IRQ_ENABLE  8'h18
`define CCP_OFS_PORT_LATCH  8'h1C
`define CCP_OFS_PIN_DIR     8'h20
`define CCP_OFS_STATUS      8'h24

// field positions
`define CCP_EVENT_BIT       0
`define CCP_STAT_CMP_BIT    0
`define CCP_STAT_PIN_BIT    1
`define CCP_STAT_PRE_LSB    2

// reset values
`define CCP_RST_MODE        4'h0
`define CCP_RST_TIMER_SEL   1'b0
`define CCP_RST_VALUE       16'h0000
`define CCP_RST_PORT_LATCH  1'b0
`define CCP_RST_PIN_DIR     1'b1

// channel mode select encodings
`define CCP_MODE_OFF        4'h0
`define CCP_MODE_CMP_TOGGLE 4'h2
`define CCP_MODE_CAP_FALL   4'h4
`define CCP_MODE_CAP_RISE   4'h5
`define CCP_MODE_CAP_RISE4  4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_CMP_SET    4'h8
`define CCP_MODE_CMP_CLEAR  4'h9
`define CCP_MODE_CMP_SWIRQ  4'hA
`define CCP_MODE_CMP_SPECIAL 4'hB

// prescaler terminal counts
`define CCP_PRE_LAST4       4'h3
`define CCP_PRE_LAST16      4'hF

`endif

// *** test/ccp_channel_checker.sv ***
module ccp_channel_checker (
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [31:0] dat_o,
    input logic        ack_o,
    input logic        irq_o,
    input logic        timer_a_reset_o,
    input logic        timer_b_reset_o,
    input logic        channel_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack not one cycle after request");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        $rose(ack_o) |-> $past(cyc_i && stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_wr_zero;
        ack_o && we_i |-> dat_o == 32'h0000_0000;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write data out");
    property p_ta_pulse;
        timer_a_reset_o |=> !timer_a_reset_o;
    endproperty
    a_ta_pulse: assert property (p_ta_pulse)
        else $error("timer a reset too long");
    property p_tb_pulse;
        timer_b_reset_o |=> !timer_b_reset_o;
    endproperty
    a_tb_pulse: assert property (p_tb_pulse)
        else $error("timer b reset too long");
    property p_one_timer;
        !(timer_a_reset_o && timer_b_reset_o);
    endproperty
    a_one_timer: assert property (p_one_timer)
        else $error("both timers reset");
    property p_irq_fall;
        $fell(irq_o) |-> ack_o;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without write");
    property p_oe_write;
        $changed(channel_pin_oe_o) |-> ack_o;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("oe moved alone");
endmodule // ccp_channel_checker

bind ccp_capture_compare_channel ccp_channel_checker chk (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .cyc_i           (cyc_i),
    .stb_i           (stb_i),
    .we_i            (we_i),
    .dat_o           (dat_o),
    .ack_o           (ack_o),
    .irq_o           (irq_o),
    .timer_a_reset_o (timer_a_reset_o),
    .timer_b_reset_o (timer_b_reset_o),
    .channel_pin_oe_o(channel_pin_oe_o)
);

// *** test/pin_timer_model.sv ***
module pin_timer_model (
    input  logic        clk_i,
    input  logic        rst_i,
    input  logic        run_i,
    input  logic        ta_rst_i,
    input  logic        tb_rst_i,
    output logic [15:0] ta_o,
    output logic [15:0] tb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // both timers count synchronously on the system clock
    always @(posedge clk_i) begin
        if (rst_i || ta_rst_i) begin
            ta_o <= 16'h0000;
        end else if (run_i) begin
            ta_o <= ta_o + 16'h0001;
        end
        if (rst_i || tb_rst_i) begin
            tb_o <= 16'h0000;
        end else if (run_i) begin
            tb_o <= tb_o + 16'h0001;
        end
    end
endmodule // pin_timer_model

// *** test/tb_ccp_capture_compare_channel.sv ***
module tb_ccp_capture_compare_channel;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
$display("unexpected %s exp %0h got %0h", n, e, s); end end
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        run = 0, pin = 0, lat = 0, s;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, q;
    logic [15:0] v;
    logic [3:0]  cm [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
    wire  [31:0] dat_o;
    wire  [15:0] ta, tb;
    wire         ack_o, irq_o, ta_r, tb_r, pin_o, pin_oe;
    int          failures = 0, compares = 0, n;
    ccp_capture_compare_channel dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .timer_a_count_i(ta), .timer_b_count_i(tb),
        .timer_a_reset_o(ta_r), .timer_b_reset_o(tb_r),
        .channel_pin_i(pin_oe ? pin_o : pin), .channel_pin_o(pin_o),
        .channel_pin_oe_o(pin_oe));
    pin_timer_model far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
        .ta_rst_i(ta_r), .tb_rst_i(tb_r), .ta_o(ta), .tb_o(tb));
    function automatic int need(input int m);
        return m == 6 ? 4 : (m == 7 ? 16 : 1);
    endfunction
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 50);
        if (k >= 50) failures++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pls(input int c);
        repeat (c) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        test_done;
    end
    initial begin
        void'($urandom(86));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h20, 0);
        `CHK("dir", 32'h1, q)
        wb(1'b0, 8'h40, 0);
        `CHK("unmapped", 32'h0, q)
        for (int i = 4; i < 8; i++) begin
            wb(1'b1, 8'h00, 0);
            wb(1'b1, 8'h00, i);
            repeat (2) begin
                wb(1'b1, 8'h14, 1);
                run <= 1'b1;
                repeat ($urandom_range(5, 60)) @(posedge clk_i);
                run <= 1'b0;
                @(posedge clk_i);
                pls(need(i) - 1);
                wb(1'b0, 8'h10, 0);
                `CHK("early flag", 1'b0, q[0])
                pls(1);
                wb(1'b0, 8'h10, 0);
                `CHK("flag", 1'b1, q[0])
                wb(1'b0, 8'h08, 0);
                v[7:0] = q[7:0];
                wb(1'b0, 8'h0C, 0);
                v[15:8] = q[7:0];
                `CHK("capture", ta, v)
            end
        end
        wb(1'b1, 8'h00, 0);
        wb(1'b1, 8'h00, 7);
        pls(2);
        wb(1'b1, 8'h00, 6);
        wb(1'b0, 8'h24, 0);
        `CHK("kept count", 4'h2, q[5:2])
        wb(1'b1, 8'h00, 0);
        wb(1'b0, 8'h24, 0);
        `CHK("count off", 4'h0, q[5:2])
        wb(1'b1, 8'h00, 5);
        wb(1'b1, 8'h14, 1);
        pls(1);
        wb(1'b1, 8'h18, 1);
        `CHK("irq", 1'b1, irq_o)
        wb(1'b1, 8'h14, 1);
        `CHK("irq clear", 1'b0, irq_o)
        wb(1'b1, 8'h18, 0);
        pls(1);
        `CHK("irq masked", 1'b0, irq_o)
        wb(1'b1, 8'h20, 0);
        `CHK("oe", 1'b1, pin_oe)
        wb(1'b1, 8'h14, 1);
        wb(1'b1, 8'h1C, 1);
        wb(1'b0, 8'h10, 0);
        `CHK("port capture", 1'b1, q[0])
        wb(1'b1, 8'h1C, 0);
        wb(1'b1, 8'h00, 0);
        for (int k = 0; k < 5; k++) begin
            s = (cm[k] == 4'hB);
            wb(1'b1, 8'h04, s);
            v = 16'((s ? tb : ta) + $urandom_range(10, 30));
            wb(1'b1, 8'h08, v[7:0]);
            wb(1'b1, 8'h0C, v[15:8]);
            wb(1'b1, 8'h00, cm[k]);
            wb(1'b1, 8'h14, 1);
            run <= 1'b1;
            n = 0;
            do wb(1'b0, 8'h10, 0); while (q[0] !== 1'b1 && ++n < 40);
            run <= 1'b0;
            `CHK("match flag", 1'b1, q[0])
            lat = cm[k] == 4'h8 ? 1'b1 : (cm[k] == 4'h9 ? 1'b0 :
                  (cm[k] == 4'h2 ? !lat : lat));
            `CHK("pin", (cm[k] < 4'hA) ? lat : 1'b0, pin_o)
            if (s) `CHK("period", 1'b1, tb < v)
        end
        wb(1'b0, 8'h24, 0);
        `CHK("latch kept", 1'b1, q[0])
        wb(1'b1, 8'h1C, 1);
        wb(1'b1, 8'h00, 0);
        wb(1'b0, 8'h24, 0);
        `CHK("latch off", 1'b0, q[0])
        wb(1'b0, 8'h1C, 0);
        `CHK("port latch", 32'h1, q)
        test_done;
    end
endmodule // tb_ccp_capture_compare_channel
